//--- core/parity_report_pkg.sv
// Package with constants and carriers for the bridge data parity reporting block
package parity_report_pkg;

   // Register offsets on the plain register port
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;
   localparam logic [3:0] OFS_IRQ_EN = 4'h2;
   localparam logic [3:0] OFS_IRQ_CLR = 4'h3;

   // Field positions
   localparam int CTL_PRI_RESP_BIT = 0;
   localparam int CTL_SEC_RESP_BIT = 1;
   localparam int STS_PRI_DPD_BIT = 0;
   localparam int STS_SEC_DPD_BIT = 1;

   // Reset values
   localparam logic [1:0] CONTROL_RESET = 2'h0;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] IRQ_EN_RESET = 2'h0;

   typedef enum logic [1:0] {
      XFER_READ = 2'h0,
      XFER_POSTED = 2'h1,
      XFER_DELAYED = 2'h2
   } xfer_kind_t;

   // Error event seen during a data phase
   typedef struct packed {
      logic valid;
      xfer_kind_t kind;
      logic upstream;
      logic on_secondary;
      logic completion;
      logic master;
      logic perr_sampled;
      logic mismatch;
   } parity_event_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage

//--- core/perr_pin_drive.sv
// Output stage for one active-low parity error pin
`timescale 1ns/10ps
module perr_pin_drive
   import parity_report_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic assert_now,
   input wire logic eligible,
   output logic perr_o,
   output logic perr_oe_n
);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         perr_o <= 1'b1;
      end else begin
         perr_o <= ~assert_now;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         perr_oe_n <= 1'b1;
      end else begin
         perr_oe_n <= ~eligible;
      end
   end

endmodule

//--- core/parity_report.sv
// Data parity detection flags and parity error pin decisions for a two-bus bridge
// Function
// - Primary detected flag: upstream read, posted, delayed write on primary, primary enable.
// - Secondary flag: downstream read, posted, delayed write on secondary, secondary enable.
// - Secondary flag lives in its own status bit apart from primary flag.
// - Secondary flag set only while bridge masters the secondary bus.
// - Secondary flag set on sampled secondary error line or own mismatch.
// - Secondary enable gates both secondary flag and secondary error output.
// - Primary error pin driven only as write target or read initiator.
// - Primary error pin asserted only with primary enable set.
// - Primary pin low for upstream read, downstream posted and delayed writes.
// - Secondary completion error on downstream delayed write forwards to primary pin.
// - That forwarding only if error not already seen on primary bus.
// - Secondary error pin driven only as write target or read initiator.
// - Secondary pin asserted on secondary bus parity error in eligible role.
// - Primary completion error on upstream delayed write forwards to secondary pin.
// - Primary flag set only as primary master, on sampled line or mismatch.
// - Upstream forwarding needs both enables and error not seen on secondary.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module parity_report
   import parity_report_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire reg_req_t reg_req,
   output logic [31:0] rdata,
   input wire parity_event_t pri_evt,
   input wire parity_event_t sec_evt,
   input wire logic pri_eligible,
   input wire logic sec_eligible,
   input wire logic pri_fwd_seen,
   input wire logic sec_fwd_seen,
   output logic pri_perr_o,
   output logic pri_perr_oe_n,
   output logic sec_perr_o,
   output logic sec_perr_oe_n,
   output logic irq
);

   logic [1:0] control_r;
   logic [1:0] status_r;
   logic [1:0] irq_en_r;
   logic [1:0] irq_sts_r;
   logic pri_resp;
   logic sec_resp;
   logic pri_err;
   logic sec_err;
   logic set_pri_dpd;
   logic set_sec_dpd;
   logic pri_assert;
   logic sec_assert;
   logic [1:0] set_vec;
   logic [1:0] clr_sts;
   logic [1:0] clr_irq;

   function automatic logic seen(input parity_event_t e);
      seen = e.valid & (e.perr_sampled | e.mismatch);
   endfunction

   function automatic logic is_kind(input parity_event_t e, input xfer_kind_t k);
      is_kind = (e.kind == k);
   endfunction

   assign pri_resp = control_r[CTL_PRI_RESP_BIT];
   assign sec_resp = control_r[CTL_SEC_RESP_BIT];
   // Error observed on the local bus, completion reports included
   assign pri_err = seen(pri_evt) & ~pri_evt.on_secondary;
   assign sec_err = seen(sec_evt) & sec_evt.on_secondary;

   // Primary flag: upstream traffic, primary bus, bridge as master
   assign set_pri_dpd = pri_err & pri_evt.upstream & pri_evt.master
      & pri_resp;
   // Secondary flag: downstream traffic, secondary bus, bridge as master
   assign set_sec_dpd = sec_err & ~sec_evt.upstream
      & sec_evt.master
      & sec_resp;

   // Primary error pin decision
   always_comb begin
      pri_assert = 1'b0;
      if (pri_err && !pri_evt.completion) begin
         case (pri_evt.kind)
            XFER_READ: pri_assert = pri_evt.upstream;
            XFER_POSTED: pri_assert = ~pri_evt.upstream;
            XFER_DELAYED: pri_assert = ~pri_evt.upstream;
            default: pri_assert = 1'b0;
         endcase
      end
      // Completion error on downstream delayed write reported by secondary target
      if (seen(sec_evt) && sec_evt.on_secondary && sec_evt.completion
         && is_kind(sec_evt, XFER_DELAYED) && !sec_evt.upstream
         && sec_evt.perr_sampled && sec_resp && !pri_fwd_seen) begin
         pri_assert = 1'b1;
      end
      pri_assert = pri_assert & pri_resp & pri_eligible;
   end

   // Secondary error pin decision
   always_comb begin
      sec_assert = 1'b0;
      if (sec_err && !sec_evt.completion) begin
         case (sec_evt.kind)
            XFER_READ: sec_assert = ~sec_evt.upstream;
            XFER_POSTED: sec_assert = sec_evt.upstream;
            XFER_DELAYED: sec_assert = sec_evt.upstream;
            default: sec_assert = 1'b0;
         endcase
      end
      // Completion error on upstream delayed write reported by primary target
      if (seen(pri_evt) && !pri_evt.on_secondary && pri_evt.completion
         && is_kind(pri_evt, XFER_DELAYED) && pri_evt.upstream
         && pri_evt.perr_sampled && pri_resp && !sec_fwd_seen) begin
         sec_assert = 1'b1;
      end
      sec_assert = sec_assert & sec_resp & sec_eligible;
   end

   perr_pin_drive u_pri_pin (
      .clk(clk),
      .rst(rst),
      .assert_now(pri_assert),
      .eligible(pri_eligible),
      .perr_o(pri_perr_o),
      .perr_oe_n(pri_perr_oe_n)
   );

   perr_pin_drive u_sec_pin (
      .clk(clk),
      .rst(rst),
      .assert_now(sec_assert),
      .eligible(sec_eligible),
      .perr_o(sec_perr_o),
      .perr_oe_n(sec_perr_oe_n)
   );

   assign set_vec = {set_sec_dpd, set_pri_dpd};
   assign clr_sts = (reg_req.wr && reg_req.addr == OFS_STATUS) ? reg_req.wdata[1:0] : 2'h0;
   assign clr_irq = (reg_req.wr && reg_req.addr == OFS_IRQ_CLR) ? reg_req.wdata[1:0] : 2'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         control_r <= CONTROL_RESET;
      end else if (reg_req.wr && reg_req.addr == OFS_CONTROL) begin
         control_r <= reg_req.wdata[1:0];
      end
   end

   // Detected flags: write one clears, a new event wins over the clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_r <= STATUS_RESET;
      end else begin
         status_r[STS_PRI_DPD_BIT] <= set_vec[0] | (status_r[0] & ~clr_sts[0]);
         status_r[STS_SEC_DPD_BIT] <= set_vec[1] | (status_r[1] & ~clr_sts[1]);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_en_r <= IRQ_EN_RESET;
      end else if (reg_req.wr && reg_req.addr == OFS_IRQ_EN) begin
         irq_en_r <= reg_req.wdata[1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_sts_r <= STATUS_RESET;
      end else begin
         irq_sts_r <= set_vec | (irq_sts_r & ~clr_irq);
      end
   end

   assign irq = |(irq_sts_r & irq_en_r);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h0;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            OFS_CONTROL: rdata <= {30'h0, control_r};
            OFS_STATUS: rdata <= {30'h0, status_r};
            OFS_IRQ_EN: rdata <= {30'h0, irq_en_r};
            OFS_IRQ_CLR: rdata <= {30'h0, irq_sts_r};
            default: rdata <= 32'h0;
         endcase
      end else begin
         rdata <= 32'h0;
      end
   end

endmodule

//--- tb/bus_agents.sv
// Bus agents presenting one parity event on the bus where it was seen
`timescale 1ns/10ps
module bus_agents
   import parity_report_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire parity_event_t ev,
   output parity_event_t pri_evt,
   output parity_event_t sec_evt
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pri_evt <= '0;
         sec_evt <= '0;
      end else begin
         pri_evt <= (go && !ev.on_secondary) ? ev : '0;
         sec_evt <= (go && ev.on_secondary) ? ev : '0;
      end
   end
endmodule

//--- tb/parity_report_asserts.sv
// Port checker for the parity reporting block
`timescale 1ns/10ps
module parity_report_asserts
   import parity_report_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire reg_req_t reg_req,
   input wire parity_event_t pri_evt,
   input wire parity_event_t sec_evt,
   input wire logic pri_eligible,
   input wire logic sec_eligible,
   input wire logic pri_fwd_seen,
   input wire logic sec_fwd_seen,
   input wire logic pri_perr_o,
   input wire logic pri_perr_oe_n,
   input wire logic sec_perr_o,
   input wire logic sec_perr_oe_n
);
   logic [1:0] ctl_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl_r <= 2'h0;
      end else if (reg_req.wr && reg_req.addr == OFS_CONTROL) begin
         ctl_r <= reg_req.wdata[1:0];
      end
   end
   wire logic pe = pri_evt.valid && (pri_evt.perr_sampled || pri_evt.mismatch);
   wire logic se = sec_evt.valid && (sec_evt.perr_sampled || sec_evt.mismatch);
   wire logic pl = pe && !pri_evt.completion && pri_eligible && ctl_r[0]
      && ((pri_evt.kind == XFER_READ) == pri_evt.upstream);
   wire logic sl = se && !sec_evt.completion && sec_eligible && ctl_r[1]
      && ((sec_evt.kind == XFER_READ) != sec_evt.upstream);
   wire logic pf = sec_evt.valid && sec_evt.completion && sec_evt.kind == XFER_DELAYED
      && !sec_evt.upstream && sec_evt.perr_sampled && !pri_fwd_seen && pri_eligible;
   wire logic sf = pri_evt.valid && pri_evt.completion && pri_evt.kind == XFER_DELAYED
      && pri_evt.upstream && pri_evt.perr_sampled && !sec_fwd_seen && sec_eligible;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_pri_cause; !pri_perr_o |-> $past(pri_eligible && ctl_r[0]); endproperty
   property p_sec_cause; !sec_perr_o |-> $past(sec_eligible && ctl_r[1]); endproperty
   property p_pri_drive; !pri_perr_o |-> !pri_perr_oe_n; endproperty
   property p_sec_drive; !sec_perr_o |-> !sec_perr_oe_n; endproperty
   property p_pri_local; pl |=> !pri_perr_o; endproperty
   property p_sec_local; sl |=> !sec_perr_o; endproperty
   property p_pri_fwd; pf && ctl_r == 2'h3 |=> !pri_perr_o; endproperty
   property p_sec_fwd; sf && ctl_r == 2'h3 |=> !sec_perr_o; endproperty
   a_pri_cause: assert property (p_pri_cause) else $error("pri pin cause");
   a_sec_cause: assert property (p_sec_cause) else $error("sec pin cause");
   a_pri_drive: assert property (p_pri_drive) else $error("pri pin drive");
   a_sec_drive: assert property (p_sec_drive) else $error("sec pin drive");
   a_pri_local: assert property (p_pri_local) else $error("pri pin local");
   a_sec_local: assert property (p_sec_local) else $error("sec pin local");
   a_pri_fwd: assert property (p_pri_fwd) else $error("pri pin fwd");
   a_sec_fwd: assert property (p_sec_fwd) else $error("sec pin fwd");
   c_pri: cover property (pl);
   c_sec: cover property (sl);
   c_fwd: cover property (pf);
endmodule
bind parity_report parity_report_asserts chk (.*);

//--- tb/bridge_data_parity_reporting_test.sv
// Testbench for the parity reporting block
`timescale 1ns/10ps
module bridge_data_parity_reporting_test
   import parity_report_pkg::*;
;
   logic clk, rst, go, pe, se, pf, sf, ppo, ppoe, spo, spoe, irq;
   reg_req_t req;
   parity_event_t ev, pev, sev;
   logic [31:0] rdata;
   int n_mismatch, check_count, cyc;
   always #12.5 clk = ~clk;
   parity_report uut (.clk(clk), .rst(rst), .reg_req(req), .rdata(rdata), .pri_evt(pev),
      .sec_evt(sev), .pri_eligible(pe), .sec_eligible(se), .pri_fwd_seen(pf),
      .sec_fwd_seen(sf), .pri_perr_o(ppo), .pri_perr_oe_n(ppoe), .sec_perr_o(spo),
      .sec_perr_oe_n(spoe), .irq(irq));
   bus_agents agents (.clk(clk), .rst(rst), .go(go), .ev(ev), .pri_evt(pev), .sec_evt(sev));
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
      #1;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e);
      @(posedge clk);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      #1;
      chk("rdata", e, rdata);
      @(posedge clk);
      #1;
      chk("rdata", 32'h0, rdata);
   endtask
   task automatic snd(parity_event_t e, logic xp, logic xs);
      @(posedge clk);
      go <= 1'b1;
      ev <= e;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
      chk("pri_perr_o", 32'(xp), 32'(ppo));
      chk("sec_perr_o", 32'(xs), 32'(spo));
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      parity_event_t e;
      logic hit;
      {clk, go, pf, sf, pe, se} = '0;
      rst = 1'b1;
      req = '0;
      ev = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_STATUS, 32'h0);
      rd(OFS_IRQ_EN, 32'h0);
      wr(4'h9, 32'h3);
      rd(4'h9, 32'h0);
      wr(OFS_CONTROL, 32'h3);
      rd(OFS_CONTROL, 32'h3);
      pe <= 1'b1;
      se <= 1'b1;
      for (int b = 0; b < 2; b++) begin
         for (int k = 0; k < 3; k++) begin
            for (int u = 0; u < 2; u++) begin
               e = '{1'b1, xfer_kind_t'(k), u[0], b[0], 1'b0, 1'b1, b[0], !b[0]};
               hit = (k == 0) == (u != b);
               snd(e, !(hit && b == 0), !(hit && b == 1));
               rd(OFS_STATUS, 32'(u != b) << b);
               wr(OFS_STATUS, 32'h3);
            end
         end
      end
      wr(OFS_IRQ_CLR, 32'h3);
      wr(OFS_IRQ_EN, 32'h3);
      e = '{1'b1, XFER_READ, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      snd(e, 1'b0, 1'b1);
      chk("irq", 32'h1, 32'(irq));
      wr(OFS_STATUS, 32'h0);
      rd(OFS_STATUS, 32'h1);
      wr(OFS_STATUS, 32'h1);
      rd(OFS_STATUS, 32'h0);
      wr(OFS_IRQ_CLR, 32'h1);
      chk("irq", 32'h0, 32'(irq));
      wr(OFS_CONTROL, 32'h2);
      snd(e, 1'b1, 1'b1);
      rd(OFS_STATUS, 32'h0);
      wr(OFS_CONTROL, 32'h1);
      e = '{1'b1, XFER_READ, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      snd(e, 1'b1, 1'b1);
      rd(OFS_STATUS, 32'h0);
      wr(OFS_CONTROL, 32'h3);
      se <= 1'b0;
      snd(e, 1'b1, 1'b1);
      chk("sec_perr_oe_n", 32'h1, 32'(spoe));
      rd(OFS_STATUS, 32'h2);
      wr(OFS_STATUS, 32'h3);
      se <= 1'b1;
      e.master = 1'b0;
      snd(e, 1'b1, 1'b0);
      rd(OFS_STATUS, 32'h0);
      e = '{1'b1, XFER_DELAYED, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      snd(e, 1'b0, 1'b1);
      pf <= 1'b1;
      snd(e, 1'b1, 1'b1);
      e = '{1'b1, XFER_DELAYED, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      snd(e, 1'b1, 1'b0);
      sf <= 1'b1;
      snd(e, 1'b1, 1'b1);
      finish_test();
   end
endmodule
